// File: fes_pkg.sv
// Shared constants and types of the whole-array erase and sleep sequencer.
// Assumes a 125 MHz system clock; all times become cycle counts here.
package fes_pkg;

   // -----------------------------------------------------------------
   // Clock and self-timed durations
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8; // System clock period
   localparam int FULL_ERASE_TIME_US = 20000; // Whole-array erase
   localparam int SLEEP_ENTRY_TIME_US = 3; // Select rise to sleep
   localparam int WAKE_TIME_US = 30; // Release to standby
   localparam int WRITE_HOLD_OFF_TIME_US = 1000; // Write lockout at power-up
   // Least times, rounded up to whole cycles
   localparam int FULL_ERASE_CYCLES =
      (FULL_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLEEP_ENTRY_CYCLES =
      (SLEEP_ENTRY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYCLES =
      (WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_HOLD_OFF_CYCLES =
      (WRITE_HOLD_OFF_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // -----------------------------------------------------------------
   // Widths, reset values and fixed patterns
   // -----------------------------------------------------------------
   localparam int TIMER_W = 24; // Wide enough for every count above
   localparam int COUNT_W = 4; // Bit counter, saturates at 9
   localparam logic [3:0] OPCODE_BITS = 4'h8; // Exact opcode length
   localparam logic [3:0] COUNT_SATURATE = 4'h9; // Means too many clocks
   localparam logic [7:0] ERASED_BYTE = 8'hff; // Every bit at one
   localparam logic [2:0] PROTECT_NONE = 3'h0; // No sector protected
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [3:0] COUNT_RESET = 4'h0;

   // -----------------------------------------------------------------
   // Opcodes
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_FULL_ERASE = 8'hc7;
   localparam logic [7:0] OP_SLEEP_ENTRY = 8'hb9;
   localparam logic [7:0] OP_SLEEP_RELEASE = 8'hab;

   // -----------------------------------------------------------------
   // Sequencer states, one-hot
   // -----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_STANDBY = 5'h01,
      ST_ERASE = 5'h02,
      ST_ENTER_SLEEP = 5'h04,
      ST_SLEEP = 5'h08,
      ST_WAKE = 5'h10
   } fes_state_type;

endpackage

// File: fes_link_if.sv
// Carries the received opcode and bit count from the serial-clock side
// to the system-clock side. Values are stable while the select is high.
`timescale 1ns/1ps
`default_nettype none
interface fes_link_if;
   logic [7:0] opcode; // Last bits shifted in, newest in bit 0
   logic [3:0] bit_count; // Clocks seen in the frame, saturating
   modport rx (output opcode, output bit_count);
   modport core (input opcode, input bit_count);
endinterface
`default_nettype wire

// File: fes_serial_rx.sv
// Serial-clock side: shifts the opcode in and counts clock edges.
// Assumes the serial clock only toggles while the select is low.
`timescale 1ns/1ps
`default_nettype none
module fes_serial_rx (
   input wire logic serial_clk,
   input wire logic reset,
   input wire logic chip_select_n,
   input wire logic serial_in,
   fes_link_if.rx link
);

   // -----------------------------------------------------------------
   // Frame state
   // -----------------------------------------------------------------
   logic armed; // High after the first edge of a frame
   logic next_armed;
   logic [7:0] shift; // Opcode shift register
   logic [7:0] next_shift;
   logic [3:0] count; // Edges in this frame
   logic [3:0] next_count;

   // Next values; the first edge of a frame restarts the count
   always_comb begin
      next_armed = 1'b1;
      if (!armed) begin
         next_shift = {7'h00, serial_in};
         next_count = 4'h1;
      end else begin
         next_shift = {shift[6:0], serial_in};
         // Saturate so an overlong frame never looks like eight bits
         if (count == fes_pkg::COUNT_SATURATE) begin
            next_count = count;
         end else begin
            next_count = count + 4'h1;
         end
      end
   end

   // Cleared by the frame's own end, since the clock stops with it
   always_ff @(posedge serial_clk or posedge reset or posedge chip_select_n)
   begin
      if (reset || chip_select_n) begin
         armed <= 1'b0;
      end else begin
         armed <= next_armed;
      end
   end

   // Opcode and count hold after the frame for the other domain
   always_ff @(posedge serial_clk or posedge reset) begin
      if (reset) begin
         shift <= fes_pkg::SHIFT_RESET;
         count <= fes_pkg::COUNT_RESET;
      end else begin
         shift <= next_shift;
         count <= next_count;
      end
   end

   assign link.opcode = shift;
   assign link.bit_count = count;

endmodule // fes_serial_rx
`default_nettype wire

// File: fes_core.sv
// Command sequencer for whole-array erase, sleep entry and release, and
// the power-up write lockout. Assumes reset is the power-on clear and the
// protect level bits come from logic on the system clock.
//
// What this block does
// - Completed erase leaves every byte at all ones
// - Erase needs the write latch set first
// - Select rise off the eighth bit discards command
// - Select rise starts timed erase, busy while running
// - Write latch cleared before the erase completes
// - Erase ignored unless all protect bits are zero
// - Idle select high means standby; sleep only from there
// - Sleep entered a fixed delay after entry command
// - Sleep ignores everything except the release command
// - Extra clocks on release make it rejected
// - Standby again one wake time after release
// - Sleep commands rejected while a cycle runs
// - Power-on clear holds all logic in reset
// - Write commands ignored during power-up hold-off
// - Power-up leaves standby with all flags clear
// - Sleep never survives power loss
`timescale 1ns/1ps
`default_nettype none
module fes_core #(
   parameter int ERASE_CYCLES = fes_pkg::FULL_ERASE_CYCLES,
   parameter int SLEEP_CYCLES = fes_pkg::SLEEP_ENTRY_CYCLES,
   parameter int WAKE_CYCLES = fes_pkg::WAKE_CYCLES,
   parameter int HOLD_OFF_CYCLES = fes_pkg::WRITE_HOLD_OFF_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic serial_in,
   input wire logic [2:0] protect_level_bits,
   output logic busy_flag,
   output logic write_latch_flag,
   output logic sleep_mode,
   output logic standby,
   output logic sector_write_lock,
   output logic sector_lockdown,
   output logic erase_done,
   output logic [7:0] erase_fill_data
);

   // -----------------------------------------------------------------
   // Serial side and crossing
   // -----------------------------------------------------------------
   fes_link_if link (); // Opcode and count from the serial domain

   fes_serial_rx u_rx (
      .serial_clk(serial_clk),
      .reset(reset),
      .chip_select_n(chip_select_n),
      .serial_in(serial_in),
      .link(link.rx)
   );

   logic cs_meta; // First stage, read only by cs_sync
   logic cs_sync; // Synchronised select
   logic cs_prev; // For rise detection
   logic frame_end; // Select rose one cycle ago
   logic frame_done; // Captured frame ready, one cycle
   logic [7:0] frame_op; // Captured opcode
   logic [3:0] frame_len; // Captured bit count
   logic next_frame_end;
   logic next_frame_done;
   logic [7:0] next_frame_op;
   logic [3:0] next_frame_len;

   // Exact eight-bit frame carrying the given opcode
   function automatic logic is_cmd(input logic [7:0] op,
                                   input logic [3:0] len,
                                   input logic [7:0] code);
      is_cmd = (len == fes_pkg::OPCODE_BITS) && (op == code);
   endfunction

   // Capture once the select is high; the serial clock is then still, so
   // the opcode and count are stable words by the time they are sampled
   always_comb begin
      next_frame_end = cs_sync && !cs_prev;
      next_frame_done = frame_end;
      next_frame_op = frame_op;
      next_frame_len = frame_len;
      if (frame_end) begin
         next_frame_op = link.opcode;
         next_frame_len = link.bit_count;
      end
   end

   // Synchroniser and capture registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
         frame_end <= 1'b0;
         frame_done <= 1'b0;
         frame_op <= fes_pkg::SHIFT_RESET;
         frame_len <= fes_pkg::COUNT_RESET;
      end else if (clk_en) begin
         cs_meta <= chip_select_n;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
         frame_end <= next_frame_end;
         frame_done <= next_frame_done;
         frame_op <= next_frame_op;
         frame_len <= next_frame_len;
      end
   end

   // -----------------------------------------------------------------
   // Power-up write hold-off
   // -----------------------------------------------------------------
   logic [fes_pkg::TIMER_W-1:0] hold_cnt; // Cycles since power-on clear
   logic [fes_pkg::TIMER_W-1:0] next_hold_cnt;
   logic hold_off_done; // Write commands accepted from here on
   logic next_hold_off_done;

   // Counts up once after the release of the power-on clear
   always_comb begin
      next_hold_cnt = hold_cnt;
      next_hold_off_done = hold_off_done;
      if (!hold_off_done) begin
         next_hold_cnt = hold_cnt + 1'b1;
         if (hold_cnt == fes_pkg::TIMER_W'(HOLD_OFF_CYCLES - 1)) begin
            next_hold_off_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hold_cnt <= '0;
         hold_off_done <= 1'b0;
      end else if (clk_en) begin
         hold_cnt <= next_hold_cnt;
         hold_off_done <= next_hold_off_done;
      end
   end

   // -----------------------------------------------------------------
   // Command sequencer
   // -----------------------------------------------------------------
   fes_pkg::fes_state_type state; // Current mode
   fes_pkg::fes_state_type next_state;
   logic [fes_pkg::TIMER_W-1:0] timer; // Remaining cycles of a timed step
   logic [fes_pkg::TIMER_W-1:0] next_timer;
   logic next_busy;
   logic next_wel;
   logic next_sleep;
   logic next_standby;
   logic next_erase_done;
   logic timer_last; // Timed step ends this cycle

   // Decode captured frames against the mode; bad lengths fall through
   always_comb begin
      next_state = state;
      next_timer = timer;
      next_wel = write_latch_flag;
      next_erase_done = 1'b0;
      timer_last = (timer == fes_pkg::TIMER_W'(1));
      if (timer != '0) begin
         next_timer = timer - 1'b1;
      end
      unique case (state)
         fes_pkg::ST_STANDBY: begin
            // Writes are locked until the power-up hold-off ends
            if (frame_done && hold_off_done) begin
               if (is_cmd(frame_op, frame_len,
                          fes_pkg::OP_WRITE_ENABLE)) begin
                  next_wel = 1'b1;
               end else if (is_cmd(frame_op, frame_len,
                                   fes_pkg::OP_WRITE_DISABLE)) begin
                  next_wel = 1'b0;
               end else if (is_cmd(frame_op, frame_len,
                                   fes_pkg::OP_FULL_ERASE)
                            && write_latch_flag
                            && protect_level_bits ==
                               fes_pkg::PROTECT_NONE) begin
                  next_state = fes_pkg::ST_ERASE;
                  next_timer = fes_pkg::TIMER_W'(ERASE_CYCLES);
                  // Latch drops at the start, well before completion
                  next_wel = 1'b0;
               end
            end
            // Sleep entry needs no write permission
            if (frame_done && is_cmd(frame_op, frame_len,
                                     fes_pkg::OP_SLEEP_ENTRY)) begin
               next_state = fes_pkg::ST_ENTER_SLEEP;
               next_timer = fes_pkg::TIMER_W'(SLEEP_CYCLES);
            end
         end
         fes_pkg::ST_ERASE: begin
            // Every frame is rejected; the running cycle is untouched
            if (timer_last) begin
               next_state = fes_pkg::ST_STANDBY;
               next_erase_done = 1'b1;
            end
         end
         fes_pkg::ST_ENTER_SLEEP: begin
            if (timer_last) begin
               next_state = fes_pkg::ST_SLEEP;
            end
         end
         fes_pkg::ST_SLEEP: begin
            // Only an exact release frame wakes; overlong ones do not
            if (frame_done && is_cmd(frame_op, frame_len,
                                     fes_pkg::OP_SLEEP_RELEASE)) begin
               next_state = fes_pkg::ST_WAKE;
               next_timer = fes_pkg::TIMER_W'(WAKE_CYCLES);
            end
         end
         fes_pkg::ST_WAKE: begin
            if (timer_last) begin
               next_state = fes_pkg::ST_STANDBY;
            end
         end
      endcase
      next_busy = (next_state == fes_pkg::ST_ERASE);
      next_sleep = (next_state == fes_pkg::ST_SLEEP) ||
                   (next_state == fes_pkg::ST_WAKE);
      next_standby = (next_state == fes_pkg::ST_STANDBY) && cs_sync;
   end

   // Power-on clear always lands in standby with flags clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= fes_pkg::ST_STANDBY;
         timer <= '0;
         busy_flag <= 1'b0;
         write_latch_flag <= 1'b0;
         sleep_mode <= 1'b0;
         standby <= 1'b0;
         sector_write_lock <= 1'b0;
         sector_lockdown <= 1'b0;
         erase_done <= 1'b0;
         erase_fill_data <= fes_pkg::ERASED_BYTE;
      end else if (clk_en) begin
         state <= next_state;
         timer <= next_timer;
         busy_flag <= next_busy;
         write_latch_flag <= next_wel;
         sleep_mode <= next_sleep;
         standby <= next_standby;
         erase_done <= next_erase_done;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_erase_latch: assert property (
      $rose(busy_flag) |-> $past(write_latch_flag))
      else $error("Erase started without the write latch");

   a_erase_protect: assert property (
      $rose(busy_flag) |-> $past(protect_level_bits) == 3'h0)
      else $error("Erase started with protected sectors");

   a_latch_clear: assert property (
      busy_flag |-> !write_latch_flag)
      else $error("Write latch still set during erase");

   a_erase_end: assert property (
      $fell(busy_flag) |-> erase_done && erase_fill_data == 8'hff)
      else $error("Erase ended without the fill pulse");

   // Only modes that decode frames; a timed step may end in the same cycle
   a_bad_length: assert property (
      clk_en && frame_done && frame_len != 4'h8 &&
      (state == fes_pkg::ST_STANDBY || state == fes_pkg::ST_SLEEP)
      |=> $stable(state))
      else $error("Frame of wrong length changed the mode");

   a_sleep_ignore: assert property (
      clk_en && state == fes_pkg::ST_SLEEP && frame_done &&
      frame_op != 8'hab |=> state == fes_pkg::ST_SLEEP)
      else $error("Sleep left by a command other than release");

   a_busy_reject: assert property (
      clk_en && busy_flag && timer > 24'h1 |=> busy_flag)
      else $error("Erase cycle disturbed by a command");

   a_hold_off: assert property (
      !hold_off_done |-> !$rose(write_latch_flag))
      else $error("Write latch set during power-up hold-off");

   a_sleep_delay: assert property (
      $rose(sleep_mode) && $past(state) == fes_pkg::ST_ENTER_SLEEP
      |-> $past(timer) == 24'h1)
      else $error("Sleep entered before its delay ran out");

   c_erase: cover property ($fell(busy_flag));
   c_sleep: cover property ($rose(sleep_mode));
   c_wake: cover property (state == fes_pkg::ST_WAKE ##1
                           state == fes_pkg::ST_STANDBY);
   c_bad: cover property (frame_done && frame_len == 4'h9);

endmodule // fes_core
`default_nettype wire

// File: fes_host_model.sv
// Host bus master model: drives select, serial clock and serial data.
// Assumes the bench calls send() only with select high for 6+ clk cycles.
`timescale 1ns/1ps
`default_nettype none
module fes_host_model (
   output logic serial_clk,
   output logic chip_select_n,
   output logic serial_in
);
   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   // Select high and clock parked low while no frame runs
   initial begin
      serial_clk = 1'b0;
      chip_select_n = 1'b1;
      serial_in = 1'b1;
   end

   // ----------------------------------------------------------------
   // One frame of len clocks, opcode MSB first, 6 ns link period
   // ----------------------------------------------------------------
   // Extra clocks beyond eight carry toggling filler bits
   task automatic send(input logic [7:0] code, input int len);
      int i;
      chip_select_n = 1'b0;
      for (i = 0; i < len; i++) begin
         serial_in = (i < 8) ? code[7 - i] : ~serial_in;
         #3 serial_clk = 1'b1;
         #3 serial_clk = 1'b0;
      end
      #3 chip_select_n = 1'b1;
      // Released data line shows the inverse, never a stale value
      serial_in = ~serial_in;
   endtask
endmodule // fes_host_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the erase and sleep sequencer.
// Assumes scaled timer parameters; the host model drives the link.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ----------------------------------------------------------------
   // Scaled counts and signals
   // ----------------------------------------------------------------
   localparam int ERASE_N = 50;
   localparam int SLEEP_N = 5;
   localparam int WAKE_N = 5;
   localparam int HOLD_N = 20;
   logic clk, reset, clk_en;
   logic [2:0] protect_level_bits;
   logic serial_clk, chip_select_n, serial_in;
   logic busy_flag, write_latch_flag, sleep_mode, standby;
   logic sector_write_lock, sector_lockdown, erase_done;
   logic [7:0] erase_fill_data;
   int mismatches, check_count, seed, i, n, m;
   time t0;

   fes_core #(.ERASE_CYCLES(ERASE_N), .SLEEP_CYCLES(SLEEP_N),
      .WAKE_CYCLES(WAKE_N), .HOLD_OFF_CYCLES(HOLD_N)) u_fes_core (
      .clk(clk), .reset(reset), .clk_en(clk_en),
      .serial_clk(serial_clk), .chip_select_n(chip_select_n),
      .serial_in(serial_in), .protect_level_bits(protect_level_bits),
      .busy_flag(busy_flag), .write_latch_flag(write_latch_flag),
      .sleep_mode(sleep_mode), .standby(standby),
      .sector_write_lock(sector_write_lock),
      .sector_lockdown(sector_lockdown), .erase_done(erase_done),
      .erase_fill_data(erase_fill_data));
   fes_host_model u_fes_host_model (.serial_clk(serial_clk),
      .chip_select_n(chip_select_n), .serial_in(serial_in));

   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   // 125 MHz system clock
   always #4 clk = ~clk;
   // Whole run needs well under 20 us; cut a hang at 200 us
   initial begin
      #200000;
      mismatches++;
      summarize();
   end

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   // Compare with four-state equality so unknowns never match
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Status as {busy, latch, sleep, standby}
   task automatic expect_st(input logic b, w, s, y);
      check({4'h0, busy_flag, write_latch_flag, sleep_mode, standby},
         {4'h0, b, w, s, y});
   endtask
   // Latch value expected after a write enable or disable frame
   function automatic logic latch_after(input logic [7:0] op,
      input logic prev);
      if (op == fes_pkg::OP_WRITE_ENABLE) return 1'b1;
      if (op == fes_pkg::OP_WRITE_DISABLE) return 1'b0;
      return prev;
   endfunction
   // Frame, then room for sync, decode and select spacing
   task automatic frame(input logic [7:0] code, input int len);
      u_fes_host_model.send(code, len);
      repeat (10) @(negedge clk);
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic do_reset();
      reset = 1'b1;
      repeat (8) @(negedge clk);
      check({sleep_mode, busy_flag, write_latch_flag}, 8'h00);
      check(erase_fill_data, fes_pkg::ERASED_BYTE);
      reset = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      reset = 1'b0;
      clk_en = 1'b1;
      protect_level_bits = 3'h0;
      mismatches = 0;
      check_count = 0;
      seed = 32'h9c303c15;
      // Raise reset after time zero so every async flop sees the edge;
      // the serial side has no other way to clear
      #1;
      do_reset();
      // Power-up state, then write enable inside the hold-off window
      expect_st(1'b0, 1'b0, 1'b0, 1'b1);
      check({sector_write_lock, sector_lockdown}, 8'h00);
      frame(fes_pkg::OP_WRITE_ENABLE, 8);
      expect_st(1'b0, 1'b0, 1'b0, 1'b1);
      $display("test power_up done");
      repeat (HOLD_N) @(negedge clk);
      // Random write enable / disable with protect bits held at zero
      for (i = 0; i < 6; i++) begin
         n = latch_after(($random(seed) & 1) ? 8'h06 : 8'h04,
            write_latch_flag);
         frame((n == 1) ? fes_pkg::OP_WRITE_ENABLE
            : fes_pkg::OP_WRITE_DISABLE, 8);
         check({7'h0, write_latch_flag}, n[7:0]);
      end
      frame(fes_pkg::OP_WRITE_ENABLE, 8);
      // Erase refused under any nonzero protect level
      for (i = 1; i < 8; i++) begin
         protect_level_bits = i[2:0];
         frame(fes_pkg::OP_FULL_ERASE, 8);
         expect_st(1'b0, 1'b1, 1'b0, 1'b1);
      end
      protect_level_bits = 3'h0;
      // Frames one clock short and one clock long are discarded
      frame(fes_pkg::OP_FULL_ERASE, 7);
      frame(fes_pkg::OP_FULL_ERASE, 9);
      expect_st(1'b0, 1'b1, 1'b0, 1'b1);
      $display("test refusals done");
      // Valid erase, sleep entry attempted while it runs
      u_fes_host_model.send(fes_pkg::OP_FULL_ERASE, 8);
      for (n = 0; n < 12 && busy_flag !== 1'b1; n++) @(negedge clk);
      t0 = $time;
      expect_st(1'b1, 1'b0, 1'b0, 1'b0);
      // Clock enable low for a random span freezes the erase timer
      m = 2 + ($random(seed) & 3);
      clk_en = 1'b0;
      repeat (m) @(negedge clk);
      expect_st(1'b1, 1'b0, 1'b0, 1'b0);
      clk_en = 1'b1;
      frame(fes_pkg::OP_SLEEP_ENTRY, 8);
      expect_st(1'b1, 1'b0, 1'b0, 1'b0);
      for (n = 0; n < 2 * ERASE_N && busy_flag === 1'b1; n++)
         @(negedge clk);
      // Frozen cycles do not count towards the erase time
      n = ($time - t0) / 8 - m;
      check({7'h0, n >= ERASE_N - 1 && n <= ERASE_N + 1}, 8'h01);
      check({7'h0, erase_done}, 8'h01);
      check(erase_fill_data, 8'hff);
      repeat (10) @(negedge clk);
      expect_st(1'b0, 1'b0, 1'b0, 1'b1);
      // Erase without the latch is ignored
      frame(fes_pkg::OP_FULL_ERASE, 8);
      expect_st(1'b0, 1'b0, 1'b0, 1'b1);
      $display("test erase done");
      // Sleep entry, then commands ignored while asleep
      frame(fes_pkg::OP_SLEEP_ENTRY, 8);
      repeat (SLEEP_N) @(negedge clk);
      expect_st(1'b0, 1'b0, 1'b1, 1'b0);
      frame(fes_pkg::OP_WRITE_ENABLE, 8);
      frame(fes_pkg::OP_FULL_ERASE, 8);
      expect_st(1'b0, 1'b0, 1'b1, 1'b0);
      frame(fes_pkg::OP_SLEEP_RELEASE, 9);
      expect_st(1'b0, 1'b0, 1'b1, 1'b0);
      frame(fes_pkg::OP_SLEEP_RELEASE, 8);
      repeat (WAKE_N) @(negedge clk);
      expect_st(1'b0, 1'b0, 1'b0, 1'b1);
      $display("test sleep done");
      // Power lost while asleep comes back in standby
      frame(fes_pkg::OP_SLEEP_ENTRY, 8);
      repeat (SLEEP_N) @(negedge clk);
      do_reset();
      expect_st(1'b0, 1'b0, 1'b0, 1'b1);
      $display("test power_cycle done");
      summarize();
   end
endmodule // testbench
`default_nettype wire
